// ===== src/jdp_top.sv
`timescale 1ns/100ps
// Summary of operation
// - four-pin 1149.1 test port with optional fifth ntrst pin.
// - port pins enabled by default; disabled mode frees them as gpio.
// - debug circuits off after reset; only firmware can enable them.
// - without firmware enable, host debug access stays blocked.
// - permanent security disables every programming, debug, test port.
// - claimed gpio: 0 off, 4/5 jtag, 2 swd, 1 trace, 3 both.
// - both ports give debug; only jtag offers scan and chaining.
// - default mode is 4-wire jtag with tms input only.
// - swd on the jtag pins makes tms bidirectional; jtag returns it to input.
// - tap reset register resets device unless ports are disabled.
// - swd enabled on one pin pair on key within 8 us window.
module jdp_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] psel_strap,
  input wire logic security_latch,
  input wire logic tck,
  input wire logic tms_in,
  output logic tms_out,
  output logic tms_oe,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic ntrst_pin,
  input wire logic usb_dp,
  input wire logic usb_dm,
  input wire logic swd_dat_out,
  input wire logic swd_drive,
  input wire logic trace_out,
  output logic [4:0] pin_claim,
  output logic debug_en,
  output logic dev_reset_req
);
  // ---------------- mclk domain ----------------
  logic [2:0] psel_reg;
  logic ocd_reg;
  logic rst_tgl_reg;
  logic [2:0] pins_used;
  logic secure_reg;
  logic cap_done_reg;
  logic [12:0] win_cnt_reg;
  logic [1:0] tck_s_reg, tms_s_reg, dp_s_reg, dm_s_reg;
  logic [2:0] rst_tgl_s_reg;
  logic acq_jtag, acq_usb, key_open, ports_live;
  jdp_pkg::jdp_status_s stat;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tck_s_reg <= '0;
      tms_s_reg <= '0;
      dp_s_reg <= '0;
      dm_s_reg <= '0;
    end else begin
      tck_s_reg <= {tck_s_reg[0], tck};
      tms_s_reg <= {tms_s_reg[0], tms_in};
      dp_s_reg <= {dp_s_reg[0], usb_dp};
      dm_s_reg <= {dm_s_reg[0], usb_dm};
    end
  end

  // strap capture after reset release
  always_ff @(posedge mclk) begin
    if (rst) begin
      cap_done_reg <= 1'b0;
      secure_reg <= 1'b0;
    end else if (!cap_done_reg) begin
      cap_done_reg <= 1'b1;
      secure_reg <= security_latch;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      psel_reg <= jdp_pkg::PSEL_RESET;
    end else if (!cap_done_reg) begin
      psel_reg <= psel_strap;
    end else if (reg_wr && reg_addr == jdp_pkg::ADDR_CTRL) begin
      psel_reg <= reg_wdata[jdp_pkg::CTRL_PSEL_LSB +: 3];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ocd_reg <= 1'b0;
    end else if (reg_wr && reg_addr == jdp_pkg::ADDR_CTRL &&
                 reg_wdata[jdp_pkg::CTRL_OCD_BIT]) begin
      ocd_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      win_cnt_reg <= '0;
    end else if (key_open) begin
      win_cnt_reg <= win_cnt_reg + 13'h0001;
    end
  end
  assign key_open = (win_cnt_reg < 13'(jdp_pkg::KEY_WIN_CYC)) && !secure_reg;

  jdp_key_detect u_key_jtag (
    .mclk(mclk),
    .rst(rst),
    .enable(key_open && !acq_usb),
    .clk_s(tck_s_reg[1]),
    .dat_s(tms_s_reg[1]),
    .found(acq_jtag)
  );
  jdp_key_detect u_key_usb (
    .mclk(mclk),
    .rst(rst),
    .enable(key_open && !acq_jtag),
    .clk_s(dp_s_reg[1]),
    .dat_s(dm_s_reg[1]),
    .found(acq_usb)
  );

  assign ports_live = !secure_reg && psel_reg != jdp_pkg::PSEL_DISABLED;
  assign debug_en = ocd_reg && !secure_reg;

  logic jtag_mode, swd_jtag_pair;
  assign jtag_mode = ports_live && !acq_jtag &&
    (psel_reg == jdp_pkg::PSEL_JTAG4 || psel_reg == jdp_pkg::PSEL_JTAG5);
  assign swd_jtag_pair = !secure_reg && (acq_jtag ||
    (ports_live && !jtag_mode && !acq_usb));

  always_comb begin
    pin_claim = 5'h00;
    pins_used = 3'h0;
    if (secure_reg) begin
      pin_claim = 5'h00;
    end else if (jtag_mode) begin
      pin_claim = (psel_reg == jdp_pkg::PSEL_JTAG5) ? 5'h1f : 5'h0f;
      pins_used = (psel_reg == jdp_pkg::PSEL_JTAG5) ? 3'h5 : 3'h4;
    end else if (swd_jtag_pair) begin
      pin_claim = (psel_reg == jdp_pkg::PSEL_SWD_TRACE) ? 5'h0b : 5'h03;
      pins_used = (psel_reg == jdp_pkg::PSEL_SWD_TRACE) ? 3'h3 : 3'h2;
    end else if (acq_usb && psel_reg == jdp_pkg::PSEL_SWD_TRACE) begin
      pin_claim = 5'h08;
      pins_used = 3'h1;
    end
  end

  assign tms_oe = swd_jtag_pair && swd_drive;
  always_ff @(posedge mclk) begin
    if (rst) begin
      tms_out <= 1'b0;
    end else begin
      tms_out <= swd_dat_out;
    end
  end

  assign stat = {key_open, acq_usb, acq_jtag, secure_reg, pins_used};

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        jdp_pkg::ADDR_CTRL: reg_rdata <= {28'h000_0000, ocd_reg, psel_reg};
        jdp_pkg::ADDR_STAT: reg_rdata <= {25'h000_0000, stat};
        jdp_pkg::ADDR_IDENT: reg_rdata <= jdp_pkg::IDCODE_VAL;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rst_tgl_s_reg <= '0;
      dev_reset_req <= 1'b0;
    end else begin
      rst_tgl_s_reg <= {rst_tgl_s_reg[1:0], rst_tgl_reg};
      dev_reset_req <= (rst_tgl_s_reg[2] ^ rst_tgl_s_reg[1]) && ports_live;
    end
  end

  // ---------------- tck domain ----------------
  logic [1:0] trst_s_reg, jen_s_reg, five_s_reg, ocd_s_reg;
  logic [3:0] ir_reg, ir_sh_reg;
  logic [31:0] dr_reg;
  logic tap_rst;
  jdp_pkg::jdp_tap_e st_reg, st_next;

  always_ff @(posedge tck) begin
    trst_s_reg <= {trst_s_reg[0], rst};
    jen_s_reg <= {jen_s_reg[0], jtag_mode};
    five_s_reg <= {five_s_reg[0], psel_reg == jdp_pkg::PSEL_JTAG5};
    ocd_s_reg <= {ocd_s_reg[0], debug_en};
  end
  assign tap_rst = trst_s_reg[1] || (five_s_reg[1] && !ntrst_pin);

  always_comb begin
    unique case (st_reg)
      jdp_pkg::TS_RESET: st_next = tms_in ? jdp_pkg::TS_RESET : jdp_pkg::TS_IDLE;
      jdp_pkg::TS_IDLE: st_next = tms_in ? jdp_pkg::TS_SEL_DR : jdp_pkg::TS_IDLE;
      jdp_pkg::TS_SEL_DR: st_next = tms_in ? jdp_pkg::TS_SEL_IR : jdp_pkg::TS_CAP_DR;
      jdp_pkg::TS_CAP_DR: st_next = tms_in ? jdp_pkg::TS_EX1_DR : jdp_pkg::TS_SH_DR;
      jdp_pkg::TS_SH_DR: st_next = tms_in ? jdp_pkg::TS_EX1_DR : jdp_pkg::TS_SH_DR;
      jdp_pkg::TS_EX1_DR: st_next = tms_in ? jdp_pkg::TS_UP_DR : jdp_pkg::TS_PA_DR;
      jdp_pkg::TS_PA_DR: st_next = tms_in ? jdp_pkg::TS_EX2_DR : jdp_pkg::TS_PA_DR;
      jdp_pkg::TS_EX2_DR: st_next = tms_in ? jdp_pkg::TS_UP_DR : jdp_pkg::TS_SH_DR;
      jdp_pkg::TS_UP_DR: st_next = tms_in ? jdp_pkg::TS_SEL_DR : jdp_pkg::TS_IDLE;
      jdp_pkg::TS_SEL_IR: st_next = tms_in ? jdp_pkg::TS_RESET : jdp_pkg::TS_CAP_IR;
      jdp_pkg::TS_CAP_IR: st_next = tms_in ? jdp_pkg::TS_EX1_IR : jdp_pkg::TS_SH_IR;
      jdp_pkg::TS_SH_IR: st_next = tms_in ? jdp_pkg::TS_EX1_IR : jdp_pkg::TS_SH_IR;
      jdp_pkg::TS_EX1_IR: st_next = tms_in ? jdp_pkg::TS_UP_IR : jdp_pkg::TS_PA_IR;
      jdp_pkg::TS_PA_IR: st_next = tms_in ? jdp_pkg::TS_EX2_IR : jdp_pkg::TS_PA_IR;
      jdp_pkg::TS_EX2_IR: st_next = tms_in ? jdp_pkg::TS_UP_IR : jdp_pkg::TS_SH_IR;
      jdp_pkg::TS_UP_IR: st_next = tms_in ? jdp_pkg::TS_SEL_DR : jdp_pkg::TS_IDLE;
      default: st_next = jdp_pkg::TS_RESET;
    endcase
  end

  always_ff @(posedge tck) begin
    if (tap_rst || !jen_s_reg[1]) begin
      st_reg <= jdp_pkg::TS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst || st_reg == jdp_pkg::TS_RESET) begin
      ir_reg <= jdp_pkg::IR_IDCODE;
      ir_sh_reg <= 4'h0;
    end else if (st_reg == jdp_pkg::TS_CAP_IR) begin
      ir_sh_reg <= 4'h1;
    end else if (st_reg == jdp_pkg::TS_SH_IR) begin
      ir_sh_reg <= {tdi, ir_sh_reg[3:1]};
    end else if (st_reg == jdp_pkg::TS_UP_IR) begin
      ir_reg <= ir_sh_reg;
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst) begin
      dr_reg <= 32'h0000_0000;
    end else if (st_reg == jdp_pkg::TS_CAP_DR) begin
      unique case (ir_reg)
        jdp_pkg::IR_IDCODE: dr_reg <= jdp_pkg::IDCODE_VAL;
        jdp_pkg::IR_DEBUG: dr_reg <= {31'h0000_0000, ocd_s_reg[1]};
        default: dr_reg <= 32'h0000_0000;
      endcase
    end else if (st_reg == jdp_pkg::TS_SH_DR) begin
      if (ir_reg == jdp_pkg::IR_IDCODE) begin
        dr_reg <= {tdi, dr_reg[31:1]};
      end else begin
        dr_reg <= {31'h0000_0000, tdi};
      end
    end
  end

  always_ff @(posedge tck) begin
    if (trst_s_reg[1]) begin
      rst_tgl_reg <= 1'b0;
    end else if (st_reg == jdp_pkg::TS_UP_DR && ir_reg == jdp_pkg::IR_DEVRST &&
                 dr_reg[0]) begin
      rst_tgl_reg <= ~rst_tgl_reg;
    end
  end

  // tdo changes on falling tck
  always_ff @(negedge tck) begin
    if (trst_s_reg[1]) begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo_oe <= jen_s_reg[1] &&
        (st_reg == jdp_pkg::TS_SH_DR || st_reg == jdp_pkg::TS_SH_IR);
      tdo_out <= (st_reg == jdp_pkg::TS_SH_IR) ? ir_sh_reg[0] : dr_reg[0];
    end
  end
endmodule

// ===== src/jdp_pkg.sv
package jdp_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_IDENT = 4'h2;
  localparam int CTRL_PSEL_LSB = 0;
  localparam int CTRL_OCD_BIT = 3;
  localparam logic [2:0] PSEL_JTAG4 = 3'h0;
  localparam logic [2:0] PSEL_JTAG5 = 3'h1;
  localparam logic [2:0] PSEL_SWD = 3'h2;
  localparam logic [2:0] PSEL_SWD_TRACE = 3'h3;
  localparam logic [2:0] PSEL_DISABLED = 3'h4;
  localparam logic [2:0] PSEL_RESET = PSEL_JTAG4;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_DEVRST = 4'h8;
  localparam logic [3:0] IR_DEBUG = 4'h9;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam int KEY_W = 16;
  // acquisition key and identity values are arbitrary
  localparam logic [15:0] SWD_KEY = 16'hb5e3;
  localparam logic [31:0] IDCODE_VAL = 32'h0123_4567;
  localparam int CLK_MHZ = 200;
  localparam int KEY_WIN_NS = 8000;
  localparam int KEY_WIN_CYC = (KEY_WIN_NS * CLK_MHZ) / 1000;
  localparam int TCK_MAX_KHZ = 8000;
  localparam int TCK_DIV_8_16 = 3;
  localparam int TCK_DIV_32 = 5;

  typedef struct packed {
    logic key_open;
    logic acq_usb;
    logic acq_jtag;
    logic secure;
    logic [2:0] pins_used;
  } jdp_status_s;

  typedef enum logic [15:0] {
    TS_RESET = 16'h0001, TS_IDLE = 16'h0002, TS_SEL_DR = 16'h0004,
    TS_CAP_DR = 16'h0008, TS_SH_DR = 16'h0010, TS_EX1_DR = 16'h0020,
    TS_PA_DR = 16'h0040, TS_EX2_DR = 16'h0080, TS_UP_DR = 16'h0100,
    TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400, TS_SH_IR = 16'h0800,
    TS_EX1_IR = 16'h1000, TS_PA_IR = 16'h2000, TS_EX2_IR = 16'h4000,
    TS_UP_IR = 16'h8000
  } jdp_tap_e;
endpackage

// ===== src/jdp_key_detect.sv
`timescale 1ns/100ps
module jdp_key_detect (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic clk_s,
  input wire logic dat_s,
  output logic found
);
  logic clk_d_reg;
  logic [jdp_pkg::KEY_W-1:0] shift_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_d_reg <= 1'b0;
      shift_reg <= '0;
    end else begin
      clk_d_reg <= clk_s;
      if (clk_s && !clk_d_reg) begin
        shift_reg <= {shift_reg[jdp_pkg::KEY_W-2:0], dat_s};
      end
    end
  end

  // sticky match within window
  always_ff @(posedge mclk) begin
    if (rst) begin
      found <= 1'b0;
    end else if (enable && shift_reg == jdp_pkg::SWD_KEY) begin
      found <= 1'b1;
    end
  end
endmodule

// ===== tb/jdp_checker.sv
`timescale 1ns/100ps
module jdp_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic security_latch,
  input wire logic tms_oe,
  input wire logic [4:0] pin_claim,
  input wire logic debug_en,
  input wire logic dev_reset_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  debug_off_a: assert property ($fell(rst) |-> !debug_en)
    else $error("debug enable high after reset");
  doc_sticky_a: assert property (debug_en |=> debug_en)
    else $error("debug enable dropped without reset");
  reset_pulse_a: assert property (dev_reset_req |=> !dev_reset_req)
    else $error("device reset request longer than one cycle");
  locked_reset_a: assert property (security_latch |-> !dev_reset_req)
    else $error("device reset while secured");
  off_reset_a: assert property (pin_claim == 5'h00 |-> !dev_reset_req)
    else $error("device reset with ports disabled");
  tms_input_a: assert property (pin_claim[2] |-> !tms_oe)
    else $error("tms driven in jtag mode");
  five_wire_a: assert property (pin_claim[4] |-> pin_claim[3:0] == 4'hf)
    else $error("ntrst claimed without the other jtag pins");
  pair_claim_a: assert property (pin_claim[0] |-> pin_claim[1])
    else $error("tms claimed without tck");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  unmapped_a: assert property (reg_rd && reg_addr > 4'h2 |=> reg_rdata == 0)
    else $error("unmapped read not zero");
endmodule
bind jdp_top jdp_checker chk (
  .mclk, .rst, .reg_addr, .reg_rd, .reg_rdata, .security_latch, .tms_oe,
  .pin_claim, .debug_en, .dev_reset_req
);

// ===== tb/jdp_host.sv
`timescale 1ns/100ps
module jdp_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic usb_dp,
  output logic usb_dm,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    usb_dp = 1'b0;
    usb_dm = 1'b0;
  end
  task automatic clk1(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    q = tdo;
    #80 tck = 1'b0;
    tdi = ~d;
  endtask
  task automatic tap_reset();
    logic q;
    repeat (5) clk1(1'b1, 1'b0, q);
    clk1(1'b0, 1'b0, q);
  endtask
  task automatic shift(input bit ir, input int n, input logic [31:0] v,
                       output logic [31:0] o);
    logic q;
    o = '0;
    clk1(1'b1, 1'b0, q);
    if (ir) clk1(1'b1, 1'b0, q);
    clk1(1'b0, 1'b0, q);
    clk1(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      clk1(i == n - 1, v[i], q);
      o[i] = q;
    end
    clk1(1'b1, 1'b0, q);
    clk1(1'b0, 1'b0, q);
  endtask
  // key msb first on one pair
  task automatic send_key(input bit usb);
    logic k;
    for (int i = 15; i >= 0; i--) begin
      k = jdp_pkg::SWD_KEY[i];
      {usb_dm, tms} = usb ? {k, tms} : {usb_dm, k};
      #80 {usb_dp, tck} = {usb, !usb};
      #80 {usb_dp, tck} = 2'b00;
    end
    usb_dm = ~usb_dm;
  endtask
endmodule

// ===== tb/tb_jdp_top.sv
`timescale 1ns/100ps
module tb_jdp_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] psel_strap = jdp_pkg::PSEL_JTAG4;
  logic security_latch = 1'b0;
  logic swd_drive = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] v;
  logic tck, host_tms, tdi, usb_dp, usb_dm, tms_out, tms_oe, tdo_out, tdo_oe;
  logic [4:0] pin_claim;
  logic debug_en, dev_reset_req;
  logic [2:0] modes [4] = '{jdp_pkg::PSEL_JTAG5, jdp_pkg::PSEL_SWD,
                            jdp_pkg::PSEL_SWD_TRACE, jdp_pkg::PSEL_DISABLED};
  logic [4:0] claims [4] = '{5'h1f, 5'h03, 5'h0b, 5'h00};
  wire logic tms_w = tms_oe ? tms_out : host_tms;
  wire logic tdo_w = tdo_oe ? tdo_out : 1'b1;
  int err_count = 0;
  int n_checks = 0;
  int pulses = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (dev_reset_req === 1'b1) pulses++;
  jdp_top dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .psel_strap(psel_strap),
    .security_latch(security_latch), .tck(tck), .tms_in(tms_w),
    .tms_out(tms_out), .tms_oe(tms_oe), .tdi(tdi), .tdo_out(tdo_out),
    .tdo_oe(tdo_oe), .ntrst_pin(1'b1), .usb_dp(usb_dp), .usb_dm(usb_dm),
    .swd_dat_out(1'b0), .swd_drive(swd_drive), .trace_out(1'b0),
    .pin_claim(pin_claim), .debug_en(debug_en),
    .dev_reset_req(dev_reset_req));
  jdp_host host (.tck(tck), .tms(host_tms), .tdi(tdi), .usb_dp(usb_dp),
    .usb_dm(usb_dm), .tdo(tdo_w));
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask
  task automatic do_reset(input logic [2:0] mode, input logic sec);
    @(posedge mclk);
    rst <= 1'b1;
    psel_strap <= mode;
    security_latch <= sec;
    host.tap_reset();
    @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    // tap is held in reset until its synchronisers clear: walk it to idle
    host.tap_reset();
    @(posedge mclk);
  endtask
  task automatic try_devrst();
    host.shift(1'b1, 4, jdp_pkg::IR_DEVRST, v);
    pulses = 0;
    host.shift(1'b0, 1, 32'h0000_0001, v);
    repeat (20) @(posedge mclk);
  endtask
  initial begin
    #200_000;
    err_count++;
    final_report();
  end
  initial begin
    do_reset(jdp_pkg::PSEL_JTAG4, 1'b0);
    check("claim", pin_claim, 5'h0f);
    check("tms_oe", tms_oe, 1'b0);
    check("debug_en", debug_en, 1'b0);
    reg_read(jdp_pkg::ADDR_STAT, v);
    check("pins_used", v[2:0], 3'h4);
    reg_read(4'h7, v);
    check("unmapped", v, 32'h0000_0000);
    host.shift(1'b0, 32, 32'h0000_0000, v);
    check("idcode", v, jdp_pkg::IDCODE_VAL);
    try_devrst();
    check("reset pulses", pulses, 1);
    reg_write(jdp_pkg::ADDR_CTRL, 32'h0000_0008);
    check("debug_en set", debug_en, 1'b1);
    reg_write(jdp_pkg::ADDR_CTRL, 32'h0000_0000);
    check("debug_en kept", debug_en, 1'b1);
    for (int i = 0; i < 4; i++) begin
      do_reset(modes[i], 1'b0);
      check("claim", pin_claim, claims[i]);
      if (i == 1 || i == 2) begin
        host.send_key(i == 2);
        repeat (8) @(posedge mclk);
        reg_read(jdp_pkg::ADDR_STAT, v);
        check("acquired", v[5:4], i == 2 ? 2'b10 : 2'b01);
      end
      if (i == 1) begin
        swd_drive <= 1'b1;
        repeat (2) @(posedge mclk);
        check("tms_oe swd", tms_oe, 1'b1);
      end
      swd_drive <= 1'b0;
    end
    swd_drive <= 1'b1;
    do_reset(jdp_pkg::PSEL_JTAG4, 1'b0);
    check("tms_oe jtag", tms_oe, 1'b0);
    swd_drive <= 1'b0;
    do_reset(jdp_pkg::PSEL_JTAG4, 1'b1);
    reg_read(jdp_pkg::ADDR_STAT, v);
    check("secure", v[3], 1'b1);
    try_devrst();
    check("locked pulses", pulses, 0);
    final_report();
  end
endmodule
